// File: pmc_pkg.sv
package pmc_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [3:0] MODE_CTRL_ADDR  = 4'h0;
	localparam logic [3:0] MODE_CTRL2_ADDR = 4'h4;
	localparam logic [3:0] STATUS_ADDR     = 4'h8;

	// ----------------------------------------------------------------
	// Field positions of system_mode_control
	// ----------------------------------------------------------------
	localparam int HLSEL_BIT = 0;
	localparam int IDLE_BIT  = 1;
	localparam int HRDY_BIT  = 2;
	localparam int LRDY_BIT  = 3;
	localparam int FAST_BIT  = 4;
	localparam int CKS_LSB   = 5;

	// ----------------------------------------------------------------
	// Field positions of system_mode_control_two and status
	// ----------------------------------------------------------------
	localparam int KEEP_BIT = 0;
	localparam int WDTEN_BIT = 1;
	localparam int WDTSRC_BIT = 2;
	localparam int DETEN_BIT = 3;
	localparam int PWRDN_BIT = 0;
	localparam int TOF_BIT   = 1;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] MODE_CTRL_RST  = 8'h03;
	localparam logic [7:0] MODE_CTRL2_RST = 8'h00;

	// ----------------------------------------------------------------
	// Oscillator start-up counts, in cycles of the oscillator itself
	// ----------------------------------------------------------------
	localparam logic [10:0] XTAL_START_CYC = 11'h400;
	localparam logic [10:0] RC_HIGH_CYC    = 11'h010;
	localparam logic [10:0] RC_LOW_CYC     = 11'h002;
	localparam logic [10:0] RUN_WAKE_CYC   = 11'h002;

	// ----------------------------------------------------------------
	// Encodings
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		HOSC_CRYSTAL = 2'b00,
		HOSC_EXT_RC  = 2'b01,
		HOSC_INT_RC  = 2'b10
	} pmc_hosc_t;

	typedef enum logic [2:0] {
		MODE_RUN      = 3'b000,
		MODE_DEEP     = 3'b001,
		MODE_KEEP     = 3'b010,
		MODE_IDLE_STP = 3'b011,
		MODE_IDLE_RUN = 3'b100,
		MODE_WAKE     = 3'b101
	} pmc_mode_t;

endpackage

// File: pmc_osc_if.sv
interface pmc_osc_if;
	import pmc_pkg::*;

	// ----------------------------------------------------------------
	// Start-up timer request and answer
	// ----------------------------------------------------------------
	logic        start;
	logic [10:0] count;
	logic        tick;
	logic        hold;
	logic        ready;

	modport ctrl (output start, output count, output tick, output hold, input ready);
	modport tmr  (input start, input count, input tick, input hold, output ready);
endinterface

// File: pmc_osc_timer.sv
module pmc_osc_timer
	import pmc_pkg::*;
(
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_sync_b,
	// Control
	pmc_osc_if.tmr    osc
);

	logic [10:0] cnt_reg;
	logic [10:0] cnt_next;
	logic        rdy_reg;
	logic        rdy_next;

	// Ready is forced low while held, counts ticks after start, rises at the count.
	always_comb begin
		cnt_next = cnt_reg;
		rdy_next = rdy_reg;
		if (osc.hold) begin
			cnt_next = 11'h000;
			rdy_next = 1'b0;
		end else if (osc.start) begin
			cnt_next = 11'h000;
			rdy_next = 1'b0;
		end else if (!rdy_reg && osc.tick) begin
			if (cnt_reg + 11'h001 >= osc.count) begin
				rdy_next = 1'b1;
			end else begin
				cnt_next = cnt_reg + 11'h001;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			cnt_reg <= 11'h000;
			rdy_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			rdy_reg <= rdy_next;
		end
	end

	assign osc.ready = rdy_reg;

endmodule

// File: pmc_ctrl.sv
// How it works
// (R1) Low-ready drops in deep sleep, rises 1024 crystal or 2 RC ticks after wake.
// (R2) High-ready low in any sleep or idle_stopped; rises 1024 or 16 ticks after wake.
// (R3) High-ready clears at power-on and sets once the fast oscillator is stable.
// (R4) Halt: idle_select 0 sleeps; 1 idles running or stopped by system_clock_keep.
// (R5) high_low_select 1 uses fast_clock; 0 uses divided fast_clock or slow_clock.
// (R6) Moving to slow_clock stops the fast oscillator and its /16 and /64 clocks.
// (R7) Fast wake only from sleep_keepalive or idle_stopped, never from deep_sleep.
// (R8) Crystal fast wake runs on sub_clock, switches after 1024 crystal ticks.
// (R9) RC system oscillators wake in their own counts; fast wake enable ignored.
// (R10) Software enters slow mode with select 0 and clock field 000 or 001.
// (R11) Slow mode switch waits for low-ready before slow_clock drives the system.
// (R12) Software returns to normal with select 1 or field 010..111, then checks ready.
// (R13) Halt, idle 0, no watchdog nor detector: deep sleep, clocks stop, watchdog cleared.
// (R14) Halt, idle 0, watchdog or detector on: keepalive, sub_clock runs, watchdog resumes; here its clock runs only when its source is sub_clock.
// (R15) idle_stopped: system clock off, time base and sub_clock on, watchdog by source.
// (R16) Any halt keeps state, sets power-down flag, clears watchdog timeout flag.
// (R17) Clock field: 000/001 slow_clock, 010..111 fast_clock divided by 64 down to 2.
// (R18) Fast wake enable only acts with the crystal, making sub_clock temporary.
// (R19) From idle_running the device resumes within two running oscillator cycles.
//
// Decided for this implementation: the address map and register access over Wishbone.
module pmc_ctrl
	import pmc_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_b,
	// Wishbone slave
	input  wire logic       wb_cyc_i,
	input  wire logic       wb_stb_i,
	input  wire logic       wb_we_i,
	input  wire logic [3:0] wb_adr_i,
	input  wire logic [3:0] wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]     wb_dat_o,
	output logic            wb_ack_o,
	// Core events and oscillator ticks
	input  wire logic       halt_req,
	input  wire logic       wake_req,
	input  wire logic       wdt_clear_req,
	input  wire logic       wdt_timeout,
	input  wire logic       fast_osc_tick,
	input  wire logic       low_osc_tick,
	input  wire logic       low_osc_is_crystal,
	input  wire logic [1:0] high_osc_type,
	// Clock controls
	output logic [2:0]      sys_clk_source,
	output logic            fast_osc_enable,
	output logic            fast_div_enable,
	output logic            sys_clk_enable,
	output logic            sub_clk_enable,
	output logic            time_base_enable,
	output logic            wdt_clk_enable,
	output logic            wdt_clear,
	output logic            cpu_run,
	output logic [2:0]      power_mode
);

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rst_meta_reg;
	logic rst_sync_b;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_reg <= 1'b0;
			rst_sync_b   <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_b   <= rst_meta_reg;
		end
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [7:0] ctrl_reg, ctrl_next;
	logic [7:0] ctrl2_reg, ctrl2_next;
	logic       pwrdn_reg, pwrdn_next;
	logic       tof_reg, tof_next;
	logic       ack_reg, ack_next;
	logic [31:0] dat_reg, dat_next;
	pmc_mode_t  mode_reg, mode_next;
	pmc_mode_t  from_reg, from_next;
	logic       subrun_reg, subrun_next;
	logic [1:0] rwc_reg, rwc_next;

	pmc_osc_if hi_if();
	pmc_osc_if lo_if();

	pmc_osc_timer u_hi (.clk_sys(clk_sys), .rst_sync_b(rst_sync_b), .osc(hi_if.tmr));
	pmc_osc_timer u_lo (.clk_sys(clk_sys), .rst_sync_b(rst_sync_b), .osc(lo_if.tmr));

	logic bus_req, wr_ctrl, wr_ctrl2;
	logic sel_slow, hi_stopped, wdt_on, keep_sub;
	logic halting, waking;

	assign bus_req  = wb_cyc_i && wb_stb_i && !ack_reg;
	assign wr_ctrl  = bus_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == MODE_CTRL_ADDR);
	assign wr_ctrl2 = bus_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == MODE_CTRL2_ADDR);

	// A codes 000 and 001 under select 0 pick slow_clock.
	assign sel_slow   = !ctrl_reg[HLSEL_BIT] && (ctrl_reg[CKS_LSB+2:CKS_LSB+1] == 2'b00); // R17
	// Only the fast oscillator stops, and only once slow_clock really drives.
	assign hi_stopped = sel_slow && lo_if.ready; // R6 R11
	assign wdt_on     = ctrl2_reg[WDTEN_BIT];
	assign keep_sub   = wdt_on || ctrl2_reg[DETEN_BIT];
	assign halting    = (mode_reg == MODE_RUN) && halt_req;
	assign waking     = wake_req && (mode_reg == MODE_DEEP || mode_reg == MODE_KEEP
		|| mode_reg == MODE_IDLE_STP || mode_reg == MODE_IDLE_RUN);

	// ----------------------------------------------------------------
	// Register file and mode sequencing
	// ----------------------------------------------------------------
	always_comb begin
		ctrl_next   = ctrl_reg;
		ctrl2_next  = ctrl2_reg;
		pwrdn_next  = pwrdn_reg;
		tof_next    = tof_reg;
		mode_next   = mode_reg;
		from_next   = from_reg;
		subrun_next = subrun_reg;
		rwc_next    = rwc_reg;
		ack_next    = bus_req;
		dat_next    = dat_reg;
		if (wr_ctrl) begin
			ctrl_next[7:4] = wb_dat_i[7:4]; // R10 R12
			ctrl_next[1:0] = wb_dat_i[1:0];
		end
		if (wr_ctrl2) begin
			ctrl2_next = wb_dat_i[7:0];
		end
		if (bus_req && !wb_we_i) begin
			case (wb_adr_i)
				MODE_CTRL_ADDR:  dat_next = {24'h000000, ctrl_reg[7:4], lo_if.ready, hi_if.ready, ctrl_reg[1:0]};
				MODE_CTRL2_ADDR: dat_next = {24'h000000, ctrl2_reg};
				STATUS_ADDR:     dat_next = {30'h0, tof_reg, pwrdn_reg};
				default:         dat_next = 32'h00000000;
			endcase
		end
		if (wdt_clear_req) begin
			pwrdn_next = 1'b0;
		end
		if (wdt_timeout) begin
			tof_next = 1'b1;
		end
		case (mode_reg)
			MODE_RUN: begin
				if (halt_req) begin
					pwrdn_next = 1'b1; // R16
					tof_next = 1'b0; // R16
					if (!ctrl_reg[IDLE_BIT]) begin
						mode_next = keep_sub ? MODE_KEEP : MODE_DEEP; // R4 R13 R14
					end else begin
						mode_next = ctrl2_reg[KEEP_BIT] ? MODE_IDLE_RUN : MODE_IDLE_STP; // R4
					end
				end
			end
			MODE_DEEP, MODE_KEEP, MODE_IDLE_STP, MODE_IDLE_RUN: begin
				if (wake_req) begin
					from_next = mode_reg;
					mode_next = MODE_WAKE;
					rwc_next  = 2'b00;
					// Crystal with fast wake and a running sub_clock lets the CPU start early.
					subrun_next = ctrl_reg[FAST_BIT] && (high_osc_type == HOSC_CRYSTAL)
						&& !sel_slow && (mode_reg == MODE_KEEP || mode_reg == MODE_IDLE_STP); // R7 R18
				end
			end
			MODE_WAKE: begin
				if (from_reg == MODE_IDLE_RUN) begin
					// Only real oscillator ticks count, so a slow oscillator stretches the wake as it should.
					if (low_osc_tick || fast_osc_tick) begin
						if (rwc_reg + 2'b01 >= RUN_WAKE_CYC[1:0]) begin
							mode_next = MODE_RUN; // R19
						end else begin
							rwc_next = rwc_reg + 2'b01;
						end
					end
				end else if (sel_slow ? lo_if.ready : hi_if.ready) begin
					mode_next   = MODE_RUN; // R9
					subrun_next = 1'b0; // R8
				end else if (subrun_reg && lo_if.ready && low_osc_tick) begin
					mode_next = MODE_RUN; // R8
				end
			end
			default: mode_next = MODE_RUN;
		endcase
		if (subrun_reg && hi_if.ready) begin
			subrun_next = 1'b0; // R8
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			ctrl_reg   <= MODE_CTRL_RST;
			ctrl2_reg  <= MODE_CTRL2_RST;
			pwrdn_reg  <= 1'b0;
			tof_reg    <= 1'b0;
			ack_reg    <= 1'b0;
			dat_reg    <= 32'h00000000;
			mode_reg   <= MODE_RUN;
			from_reg   <= MODE_RUN;
			subrun_reg <= 1'b0;
			rwc_reg    <= 2'b00;
		end else begin
			ctrl_reg   <= ctrl_next;
			ctrl2_reg  <= ctrl2_next;
			pwrdn_reg  <= pwrdn_next;
			tof_reg    <= tof_next;
			ack_reg    <= ack_next;
			dat_reg    <= dat_next;
			mode_reg   <= mode_next;
			from_reg   <= from_next;
			subrun_reg <= subrun_next;
			rwc_reg    <= rwc_next;
		end
	end

	// ----------------------------------------------------------------
	// Oscillator start-up timers
	// ----------------------------------------------------------------
	logic hi_off;
	// The fast oscillator is off in every sleep and in idle_stopped, and in slow mode.
	assign hi_off = mode_reg == MODE_DEEP || mode_reg == MODE_KEEP || mode_reg == MODE_IDLE_STP
		|| hi_stopped; // R2 R6
	assign hi_if.hold  = hi_off; // R2 R3
	assign hi_if.start = 1'b0;
	assign hi_if.tick  = fast_osc_tick;
	assign hi_if.count = (high_osc_type == HOSC_CRYSTAL) ? XTAL_START_CYC : RC_HIGH_CYC; // R2 R9
	assign lo_if.hold  = (mode_reg == MODE_DEEP); // R1
	assign lo_if.start = 1'b0;
	assign lo_if.tick  = low_osc_tick;
	assign lo_if.count = low_osc_is_crystal ? XTAL_START_CYC : RC_LOW_CYC; // R1

	// ----------------------------------------------------------------
	// Clock gating outputs
	// ----------------------------------------------------------------
	// Source codes: 000 low oscillator, 001 undivided fast_clock, 010 to 111 fast_clock divided by 64 down to 2.
	// Slow code 001 is folded onto 000 so that slow_clock stays apart from source code 001, the undivided fast_clock.
	always_comb begin
		if (subrun_reg) begin
			sys_clk_source = 3'b000; // R8
		end else if (ctrl_reg[HLSEL_BIT]) begin
			sys_clk_source = 3'b001; // R5
		end else if (sel_slow && !lo_if.ready) begin
			sys_clk_source = 3'b010; // R11
		end else if (sel_slow) begin
			sys_clk_source = 3'b000; // R17
		end else begin
			sys_clk_source = ctrl_reg[CKS_LSB+2:CKS_LSB]; // R5 R17
		end
	end

	assign fast_osc_enable  = !hi_off;
	assign fast_div_enable  = !hi_off; // R6
	assign sys_clk_enable   = (mode_reg == MODE_RUN) || (mode_reg == MODE_IDLE_RUN)
		|| (mode_reg == MODE_WAKE && (hi_if.ready || lo_if.ready || subrun_reg)); // R15
	assign sub_clk_enable   = (mode_reg != MODE_DEEP); // R13 R14
	assign time_base_enable = (mode_reg != MODE_DEEP) && (mode_reg != MODE_KEEP); // R13 R14 R15
	assign wdt_clk_enable   = wdt_on && (ctrl2_reg[WDTSRC_BIT] ? sub_clk_enable : sys_clk_enable); // R15
	assign wdt_clear        = halting; // R13 R14 R15
	assign cpu_run          = (mode_reg == MODE_RUN);
	assign power_mode       = mode_reg;
	assign wb_ack_o         = ack_reg;
	assign wb_dat_o         = dat_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_deep_lowready: assert property (@(posedge clk_sys) disable iff (!rst_sync_b) // R1
		mode_reg == MODE_DEEP |=> !lo_if.ready) else $error("low ready high in deep sleep");
	a_sleep_hiready: assert property (@(posedge clk_sys) disable iff (!rst_sync_b) // R2
		(mode_reg == MODE_KEEP || mode_reg == MODE_IDLE_STP) |=> !hi_if.ready) else $error("high ready in sleep");
	a_halt_sleep: assert property (@(posedge clk_sys) disable iff (!rst_sync_b) // R13
		halting && !ctrl_reg[IDLE_BIT] && !keep_sub |=> mode_reg == MODE_DEEP) else $error("no deep sleep");
	a_halt_keep: assert property (@(posedge clk_sys) disable iff (!rst_sync_b) // R14
		halting && !ctrl_reg[IDLE_BIT] && keep_sub |=> mode_reg == MODE_KEEP) else $error("no keepalive");
	a_halt_idle: assert property (@(posedge clk_sys) disable iff (!rst_sync_b) // R4
		halting && ctrl_reg[IDLE_BIT] |=> mode_reg == (ctrl2_reg[KEEP_BIT] ? MODE_IDLE_RUN : MODE_IDLE_STP))
		else $error("wrong idle mode");
	a_halt_flags: assert property (@(posedge clk_sys) disable iff (!rst_sync_b) // R16
		halting |=> pwrdn_reg && !tof_reg) else $error("halt flags wrong");
	a_full_speed: assert property (@(posedge clk_sys) disable iff (!rst_sync_b) // R5
		ctrl_reg[HLSEL_BIT] && !subrun_reg |-> sys_clk_source == 3'b001) else $error("not undivided");
	a_slow_stops: assert property (@(posedge clk_sys) disable iff (!rst_sync_b) // R6
		hi_stopped |-> !fast_div_enable && !fast_osc_enable) else $error("fast clock left on");
	a_slow_wait: assert property (@(posedge clk_sys) disable iff (!rst_sync_b) // R11
		mode_reg == MODE_RUN && sel_slow && !lo_if.ready && !subrun_reg |-> sys_clk_source == 3'b010
		&& fast_osc_enable) else $error("slow clock used before ready");
	a_deep_fast: assert property (@(posedge clk_sys) disable iff (!rst_sync_b) // R7
		waking && mode_reg == MODE_DEEP |=> !subrun_reg) else $error("fast wake from deep");
	a_rc_no_fast: assert property (@(posedge clk_sys) disable iff (!rst_sync_b) // R9
		waking && high_osc_type != HOSC_CRYSTAL |=> !subrun_reg) else $error("fast wake without crystal");
	a_xtal_switch: assert property (@(posedge clk_sys) disable iff (!rst_sync_b) // R8
		subrun_reg && hi_if.ready |=> !subrun_reg) else $error("substitute clock kept after ready");
	a_deep_clocks: assert property (@(posedge clk_sys) disable iff (!rst_sync_b) // R13
		mode_reg == MODE_DEEP |-> !sys_clk_enable && !sub_clk_enable && !time_base_enable && !wdt_clk_enable)
		else $error("deep sleep clocks wrong");
	a_keep_clocks: assert property (@(posedge clk_sys) disable iff (!rst_sync_b) // R14
		mode_reg == MODE_KEEP |-> !sys_clk_enable && sub_clk_enable && !time_base_enable)
		else $error("keepalive clocks wrong");
	a_idle_clocks: assert property (@(posedge clk_sys) disable iff (!rst_sync_b) // R15
		mode_reg == MODE_IDLE_STP |-> !sys_clk_enable && sub_clk_enable && time_base_enable)
		else $error("idle_stopped clocks wrong");
	a_idle_run_clocks: assert property (@(posedge clk_sys) disable iff (!rst_sync_b) // R4
		mode_reg == MODE_IDLE_RUN |-> sys_clk_enable && time_base_enable && !cpu_run)
		else $error("idle_running clocks wrong");
	a_run_wake: assert property (@(posedge clk_sys) disable iff (!rst_sync_b) // R19
		(mode_reg == MODE_WAKE && from_reg == MODE_IDLE_RUN && (low_osc_tick || fast_osc_tick))[*2]
		|=> mode_reg == MODE_RUN) else $error("idle_running slow wake");
	c_deep: cover property (@(posedge clk_sys) mode_reg == MODE_DEEP ##[1:50] mode_reg == MODE_RUN);
	c_fast_wake: cover property (@(posedge clk_sys) subrun_reg && mode_reg == MODE_RUN);
	c_slow: cover property (@(posedge clk_sys) hi_stopped);
	c_idle_run: cover property (@(posedge clk_sys) mode_reg == MODE_IDLE_RUN ##[1:10] mode_reg == MODE_RUN);

endmodule

// File: pmc_ctrl_tb_top.sv
module pmc_ctrl_tb_top
	import pmc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic        clk_sys, rst_b, wb_cyc, wb_stb, wb_we, wb_ack;
	logic [3:0]  wb_adr, wb_sel;
	logic [31:0] wb_dat_w, wb_dat_r, q;
	logic        halt_req, wake_req, wdt_clear_req, wdt_timeout;
	logic        fast_osc_tick, low_osc_tick, low_osc_is_crystal;
	logic [1:0]  high_osc_type;
	logic [2:0]  sys_clk_source, power_mode, low_div;
	logic        fast_osc_enable, fast_div_enable, sys_clk_enable, sub_clk_enable;
	logic        time_base_enable, wdt_clk_enable, wdt_clear, cpu_run;
	int          num_errors, checks_done, cycles, n;

	pmc_ctrl pmc_ctrl_i (
		.clk_sys(clk_sys), .rst_b(rst_b), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack),
		.halt_req(halt_req), .wake_req(wake_req), .wdt_clear_req(wdt_clear_req), .wdt_timeout(wdt_timeout),
		.fast_osc_tick(fast_osc_tick), .low_osc_tick(low_osc_tick), .low_osc_is_crystal(low_osc_is_crystal),
		.high_osc_type(high_osc_type), .sys_clk_source(sys_clk_source), .fast_osc_enable(fast_osc_enable),
		.fast_div_enable(fast_div_enable), .sys_clk_enable(sys_clk_enable), .sub_clk_enable(sub_clk_enable),
		.time_base_enable(time_base_enable), .wdt_clk_enable(wdt_clk_enable), .wdt_clear(wdt_clear),
		.cpu_run(cpu_run), .power_mode(power_mode)
	);

	// ----------------------------------------------------------------
	// Clock, slow oscillator ticks and hang guard
	// ----------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// The low oscillator ticks every eighth cycle so its ready count is visibly slower than the fast one.
	always @(posedge clk_sys) begin
		low_div <= low_div + 3'h1;
		low_osc_tick <= (low_div == 3'h7);
		cycles++;
		if (cycles == 12000) begin
			num_errors++;
			$display("Error timeout expected finish seen hang");
			test_done();
		end
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic test_done();
		$display("Checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wb_xfer(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [7:0] d);
		@(posedge clk_sys);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_sel <= s;
		wb_dat_w <= {24'h000000, d};
		do begin
			@(posedge clk_sys);
		end while (wb_ack !== 1'b1);
		q = wb_dat_r;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		wb_xfer(1'b1, a, 4'h1, d);
	endtask

	task automatic rd(input logic [3:0] a);
		wb_xfer(1'b0, a, 4'h1, 8'h00);
	endtask

	// Bounded so that a source that never settles is reported rather than hanging the run.
	task automatic wait_src(input logic [2:0] s);
		n = 0;
		while (sys_clk_source !== s && n < 50) begin
			@(posedge clk_sys);
			n++;
		end
		#1;
	endtask

	task automatic halt_case(input string nm, input logic [7:0] ctl, input logic [7:0] ctl2,
		input logic [2:0] m, input logic [4:0] en, input int lo, input int hi);
		wr(MODE_CTRL_ADDR, ctl);
		wr(MODE_CTRL2_ADDR, ctl2);
		@(posedge clk_sys);
		wdt_timeout <= 1'b1;
		@(posedge clk_sys);
		wdt_timeout <= 1'b0;
		halt_req <= 1'b1;
		#1 check("wdt clear", 32'h1, {31'h0, wdt_clear});
		@(posedge clk_sys);
		halt_req <= 1'b0;
		#1 check("halt mode", {29'h0, m}, {29'h0, power_mode});
		check("clock enables", {27'h0, en},
			{27'h0, sys_clk_enable, sub_clk_enable, time_base_enable, wdt_clk_enable, cpu_run});
		rd(STATUS_ADDR);
		check("status at halt", 32'h1, q);
		rd(MODE_CTRL_ADDR);
		check("ready flags at halt", (m == MODE_DEEP) ? 32'h0 : (m == MODE_IDLE_RUN) ? 32'h3 : 32'h2,
			{30'h0, q[3:2]});
		@(posedge clk_sys);
		wake_req <= 1'b1;
		@(posedge clk_sys);
		wake_req <= 1'b0;
		#1 check("waking mode", {29'h0, MODE_WAKE}, {29'h0, power_mode});
		n = 0;
		while (power_mode !== MODE_RUN) begin
			@(posedge clk_sys);
			n++;
		end
		check("wake time", 32'h1, {31'h0, (n >= lo && n <= hi)});
		$display("test %s done", nm);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic test_regs();
		rd(MODE_CTRL_ADDR);
		check("control reset", 32'h3, q);
		rd(MODE_CTRL2_ADDR);
		check("control_two reset", 32'h0, q);
		rd(4'hC);
		check("unmapped read", 32'h0, q);
		repeat (40) @(posedge clk_sys);
		rd(MODE_CTRL_ADDR);
		check("ready after power-on", 32'hF, q);
		wb_xfer(1'b1, MODE_CTRL_ADDR, 4'h0, 8'hE0);
		rd(MODE_CTRL_ADDR);
		check("write without lane", 32'hF, q);
		wr(MODE_CTRL_ADDR, 8'h01);
		rd(MODE_CTRL_ADDR);
		check("read-only flags", 32'hD, q);
		$display("test regs done");
	endtask

	task automatic test_clock_select();
		for (int c = 2; c < 8; c++) begin
			wr(MODE_CTRL_ADDR, {c[2:0], 5'h02});
			#1 check("divided source", 32'(c), {29'h0, sys_clk_source});
			check("fast osc kept", 32'h1, {31'h0, fast_osc_enable});
		end
		for (int c = 0; c < 2; c++) begin
			wr(MODE_CTRL_ADDR, {c[2:0], 5'h02});
			wait_src(3'h0);
			check("slow source", 32'h0, {29'h0, sys_clk_source});
			check("fast osc off", 32'h0, {30'h0, fast_osc_enable, fast_div_enable});
		end
		wr(MODE_CTRL_ADDR, 8'h03);
		wait_src(3'h1);
		check("undivided source", 32'h1, {29'h0, sys_clk_source});
		repeat (40) @(posedge clk_sys);
		rd(MODE_CTRL_ADDR);
		check("fast ready back", 32'hF, q);
		$display("test clock select done");
	endtask

	task automatic test_status();
		@(posedge clk_sys);
		wdt_clear_req <= 1'b1;
		@(posedge clk_sys);
		wdt_clear_req <= 1'b0;
		wdt_timeout <= 1'b1;
		@(posedge clk_sys);
		wdt_timeout <= 1'b0;
		rd(STATUS_ADDR);
		check("status after clear", 32'h2, q);
		$display("test status done");
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{rst_b, wb_cyc, wb_stb, wb_we, halt_req, wake_req, wdt_clear_req, wdt_timeout} = 8'h00;
		{wb_adr, wb_sel, wb_dat_w} = 40'h0;
		fast_osc_tick = 1'b1;
		low_osc_tick = 1'b0;
		low_osc_is_crystal = 1'b0;
		high_osc_type = HOSC_INT_RC;
		low_div = 3'h0;
		{num_errors, checks_done, cycles, n} = '0;
		repeat (16) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk_sys);
		test_regs();
		test_clock_select();
		halt_case("deep", 8'h01, 8'h00, MODE_DEEP, 5'b00000, 14, 20);
		halt_case("keep wdt", 8'h01, 8'h06, MODE_KEEP, 5'b01010, 14, 20);
		halt_case("keep det", 8'h01, 8'h08, MODE_KEEP, 5'b01000, 14, 20);
		halt_case("idle sub", 8'h03, 8'h06, MODE_IDLE_STP, 5'b01110, 14, 20);
		halt_case("idle sys", 8'h03, 8'h02, MODE_IDLE_STP, 5'b01100, 14, 20);
		halt_case("idle run", 8'h03, 8'h01, MODE_IDLE_RUN, 5'b11100, 1, 4);
		halt_case("rc fast", 8'h11, 8'h06, MODE_KEEP, 5'b01010, 14, 20);
		@(posedge clk_sys);
		high_osc_type <= HOSC_CRYSTAL;
		halt_case("xtal deep", 8'h11, 8'h00, MODE_DEEP, 5'b00000, 1022, 1030);
		halt_case("xtal fast", 8'h11, 8'h06, MODE_KEEP, 5'b01010, 1, 20);
		#1 check("temporary source", 32'h0, {29'h0, sys_clk_source});
		repeat (1100) @(posedge clk_sys);
		#1 check("crystal source", 32'h1, {29'h0, sys_clk_source});
		rd(MODE_CTRL_ADDR);
		check("crystal ready", 32'h1, {31'h0, q[HRDY_BIT]});
		low_osc_is_crystal <= 1'b1;
		halt_case("xtal low", 8'h11, 8'h00, MODE_DEEP, 5'b00000, 1022, 1030);
		rd(MODE_CTRL_ADDR);
		check("crystal low still starting", 32'h0, {31'h0, q[LRDY_BIT]});
		test_status();
		test_done();
	end
endmodule
